// ---- rtl/serial_line_arbiter.sv ----
/*
 * Serial line arbiter: 9-bit counter with overflow, used for bus
 * arbitration, bit time recovery and break length measurement.
 * Assumes an Avalon-MM master on clk_i, a one-cycle prescaler tick
 * and the transmitter output from logic on the same clock, and the
 * receive pin arriving asynchronously.
 */
// Register access over Avalon-MM and the register offsets were decided locally.
//
// Operation
// - nine-bit up-counter plus overflow bit
// - mode 00 idle, 01 measure, 10 arbitrate
// - reset clears mode, idle, counter cleared
// - lost flag read-only, cleared by upper-mode zero
// - clock select picks half prescaler or half bus
// - finished flag set on done, write clears
// - running flag shows counter counting
// - overflow flag set on wrap, write clears
// - mode 00 holds counter cleared
// - msb in control, low byte in count
// - bus clock: fall starts, next fall stops
// - running high between the two falls
// - prescaler clock: low starts, rise stops
// - already low at enable starts at once
// - arbitration restarts on transmit rising edge
// - sample receive at 38h or 08h
// - lost forces transmit pin high
// - early transmit low resets and stops counter unless lost
`timescale 1ns/1ps

module serial_line_arbiter (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [3:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [3:0]  byteenable_i,
    input  wire logic [31:0] writedata_i,
    output logic      [31:0] readdata_o,
    output logic             waitrequest_o,
    input  wire logic        presc_tick_i,
    input  wire logic        tx_internal_i,
    input  wire logic        rx_pin_i,
    output logic             tx_pin_o,
    output serial_line_arbiter_pkg::ctrl_view_t status_o
);
    import serial_line_arbiter_pkg::*;

    ////////////////////////////////////////////////////////////////
    // state

    logic        ack_q;
    logic [31:0] rdata_q;
    logic [1:0]  mode_q;
    logic        csel_q;
    logic        lost_q;
    logic        fin_q;
    logic        ovf_q;
    logic [8:0]  cnt_q;
    logic [8:0]  cnt_d;
    logic        phase_q;
    logic        rx_meta_q;
    logic        rx_sync_q;
    logic        rx_prev_q;
    logic        tx_prev_q;
    run_state_t  state_q;
    run_state_t  state_d;

    ////////////////////////////////////////////////////////////////
    // register bus decode

    wire req       = read_i | write_i;
    wire hit_ctrl  = (address_i == CTRL_OFS);
    wire hit_count = (address_i == COUNT_OFS);
    wire wr_take   = write_i & ack_q;
    // a write to byte lane 0 of the control word
    wire ctrl_wr   = wr_take & hit_ctrl & byteenable_i[0];
    wire [1:0] wr_mode = {writedata_i[MODE_HI], writedata_i[MODE_LO]};

    // one wait cycle, then the answer; lets read data come from a flop
    assign waitrequest_o = req & ~ack_q;
    assign readdata_o    = rdata_q;

    ////////////////////////////////////////////////////////////////
    // receive pin synchroniser and edges

    function automatic logic rise_of(input logic prev, input logic now);
        rise_of = ~prev & now;
    endfunction

    function automatic logic fall_of(input logic prev, input logic now);
        fall_of = prev & ~now;
    endfunction

    wire rx_fall = fall_of(rx_prev_q, rx_sync_q);
    wire rx_rise = rise_of(rx_prev_q, rx_sync_q);
    wire tx_rise = rise_of(tx_prev_q, tx_internal_i);
    wire tx_fall = fall_of(tx_prev_q, tx_internal_i);

    ////////////////////////////////////////////////////////////////
    // counter advance: half of the chosen source

    // prescaler tick is a same-clock pulse, so no second clock domain
    wire src_tick = csel_q ? presc_tick_i : 1'b1;
    wire advance  = src_tick & phase_q;
    wire running  = (state_q == ST_COUNTING);
    wire step     = running & advance;

    function automatic logic [8:0] sample_point(input logic sel);
        sample_point = sel ? SAMPLE_PRE : SAMPLE_BUS;
    endfunction

    wire is_meas = (mode_q == MODE_MEAS);
    wire is_arb  = (mode_q == MODE_ARB);
    // reserved mode 11 falls through to idle rather than doing harm
    wire is_idle = ~is_meas & ~is_arb;

    // counting edge that lands on the sample point; the compare uses
    // the count before the increment, so the sample falls as it arrives
    wire at_sample = is_arb & step
                   & (cnt_q == sample_point(csel_q) - 9'h001);
    wire lost_set  = at_sample & ~rx_sync_q;
    // the count wraps silently; only the sticky flag records it
    wire wrap      = step & (cnt_q == CNT_MAX);

    // measurement start and stop
    wire meas_start = is_meas & ~running & ~fin_q
                    & (csel_q ? ~rx_sync_q : rx_fall);
    wire meas_stop  = is_meas & running
                    & (csel_q ? rx_rise : rx_fall);
    wire fin_set    = meas_stop;

    // arbitration restart and abort
    wire arb_start  = is_arb & tx_rise;
    wire arb_abort  = is_arb & running & tx_fall & ~lost_q;

    // run state and counter share one view of start and stop
    wire start_now  = meas_start | arb_start;
    wire stop_now   = meas_stop | arb_abort;
    wire cnt_clear  = meas_start | arb_start | arb_abort;
    wire cnt_zero   = is_idle | ctrl_wr;

    ////////////////////////////////////////////////////////////////
    // run state

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_STOPPED: begin
                if (start_now) begin
                    state_d = ST_COUNTING;
                end
            end
            ST_COUNTING: begin
                if (stop_now) begin
                    state_d = ST_STOPPED;
                end
            end
            default: begin
                state_d = ST_STOPPED;
            end
        endcase
        if (is_idle) begin
            state_d = ST_STOPPED;
        end
        if (arb_start) begin
            state_d = ST_COUNTING;
        end
    end

    ////////////////////////////////////////////////////////////////
    // counter next value

    always_comb begin
        // later assignments take priority over earlier ones
        cnt_d = cnt_q;
        if (step) begin
            cnt_d = cnt_q + 9'h001;
        end
        if (cnt_clear) begin
            cnt_d = CNT_RST;
        end
        if (meas_stop) begin
            cnt_d = cnt_q;
        end
        if (cnt_zero) begin
            cnt_d = CNT_RST;
        end
    end

    ////////////////////////////////////////////////////////////////
    // bus answer

    wire [7:0] ctrl_rd = {lost_q, csel_q, mode_q, fin_q,
                          running, ovf_q, cnt_q[8]};
    wire [7:0] rd_byte = hit_ctrl  ? ctrl_rd
                       : hit_count ? cnt_q[7:0]
                       : 8'h00;

    // read data latch in the wait cycle, so it stands with the answer
    wire rd_take = read_i & ~ack_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_take) begin
            rdata_q <= {24'h00_0000, rd_byte};
        end
    end

    ////////////////////////////////////////////////////////////////
    // control fields

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mode_q <= MODE_RST;
        end else if (ctrl_wr) begin
            mode_q <= wr_mode;
        end
    end

    // switching source mid-count is allowed; the write clears the count
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            csel_q <= CSEL_RST;
        end else if (ctrl_wr) begin
            csel_q <= writedata_i[CSEL_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////
    // flags: a set in the clearing cycle wins

    // only a zero in the upper mode bit releases a lost node
    wire lost_clr = ctrl_wr & ~writedata_i[MODE_HI];
    wire fin_clr  = ctrl_wr;
    wire ovf_clr  = ctrl_wr;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            lost_q <= 1'b0;
        end else if (lost_set) begin
            lost_q <= 1'b1;
        end else if (lost_clr) begin
            lost_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            fin_q <= 1'b0;
        end else if (fin_set) begin
            fin_q <= 1'b1;
        end else if (fin_clr) begin
            fin_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ovf_q <= 1'b0;
        end else if (wrap) begin
            ovf_q <= 1'b1;
        end else if (ovf_clr) begin
            ovf_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // counter, divider and run state

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= CNT_RST;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // divider runs in every mode, so a count may start on either phase
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= phase_q ^ src_tick;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q <= ST_STOPPED;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // edge history

    // receive pin is asynchronous; edges show two clocks late, and
    // since both ends of a measurement carry that lag it cancels out
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end else begin
            rx_meta_q <= rx_pin_i;
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_sync_q;
        end
    end

    // transmitter output is on this clock; idle high avoids a false rise
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_prev_q <= 1'b1;
        end else begin
            tx_prev_q <= tx_internal_i;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs

    // a lost node goes recessive so the winner's frame survives
    assign tx_pin_o = tx_internal_i | lost_q;

    assign status_o = '{lost: lost_q, csel: csel_q, mode: mode_q,
                        fin: fin_q, run: running, ovf: ovf_q,
                        msb: cnt_q[8]};

endmodule

// ---- rtl/serial_line_arbiter_pkg.sv ----
/*
 * Constants and types for the serial line arbiter.
 * Assumes a 32-bit Avalon-MM register slave and a 20 MHz bus clock.
 */
package serial_line_arbiter_pkg;

    // byte offsets of the register words
    localparam logic [3:0] CTRL_OFS  = 4'h0;
    localparam logic [3:0] COUNT_OFS = 4'h4;

    // control register field positions
    localparam int LOST_BIT = 7;
    localparam int CSEL_BIT = 6;
    localparam int MODE_HI  = 5;
    localparam int MODE_LO  = 4;
    localparam int FIN_BIT  = 3;
    localparam int RUN_BIT  = 2;
    localparam int OVF_BIT  = 1;
    localparam int MSB_BIT  = 0;

    // reset values
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic       CSEL_RST = 1'h0;
    localparam logic [8:0] CNT_RST  = 9'h000;

    // mode field encodings
    localparam logic [1:0] MODE_IDLE = 2'h0;
    localparam logic [1:0] MODE_MEAS = 2'h1;
    localparam logic [1:0] MODE_ARB  = 2'h2;

    // arbitration sample points and counter maximum
    localparam logic [8:0] SAMPLE_BUS = 9'h038;
    localparam logic [8:0] SAMPLE_PRE = 9'h008;
    localparam logic [8:0] CNT_MAX    = 9'h1ff;

    typedef enum logic [1:0] {
        ST_STOPPED  = 2'b01,
        ST_COUNTING = 2'b10
    } run_state_t;

    // software view of the control register
    typedef struct packed {
        logic       lost;
        logic       csel;
        logic [1:0] mode;
        logic       fin;
        logic       run;
        logic       ovf;
        logic       msb;
    } ctrl_view_t;

endpackage

// ---- testbench/serial_line_arbiter_checker.sv ----
/*
 * Port-level checker for the serial line arbiter.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps

module serial_line_arbiter_checker (
    input wire logic                               clk_i,
    input wire logic                               rst_n_i,
    input wire logic [3:0]                         address_i,
    input wire logic                               read_i,
    input wire logic                               write_i,
    input wire logic [3:0]                         byteenable_i,
    input wire logic [31:0]                        writedata_i,
    input wire logic                               waitrequest_o,
    input wire logic                               tx_internal_i,
    input wire logic                               tx_pin_o,
    input wire serial_line_arbiter_pkg::ctrl_view_t status_o
);
    import serial_line_arbiter_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic cw;
    assign cw = write_i && !waitrequest_o && address_i == CTRL_OFS && byteenable_i[0];
    ////////////////////////////////////////////////////////////////////////
    tx_force_a: assert property (tx_pin_o == (tx_internal_i | status_o.lost))
        else $error("transmit pin not forced by lost flag");
    wait_one_a: assert property ($rose(read_i || write_i) |-> waitrequest_o ##1 !waitrequest_o)
        else $error("bus answer not after one wait cycle");
    idle_hold_a: assert property (status_o.mode == MODE_IDLE && $past(status_o.mode) == MODE_IDLE
        |-> !status_o.run && !status_o.msb) else $error("idle counter not held");
    ctrl_clear_a: assert property (cw |=> !status_o.msb && !status_o.ovf)
        else $error("control write did not clear counter");
    ovf_keep_a: assert property (status_o.ovf && !cw |=> status_o.ovf)
        else $error("overflow flag dropped");
    lost_keep_a: assert property (status_o.lost && !(cw && !writedata_i[MODE_HI]) |=> status_o.lost)
        else $error("lost flag dropped");
    lost_clr_a: assert property (cw && !writedata_i[MODE_HI] |=> !status_o.lost)
        else $error("lost flag not cleared");
    lost_arb_a: assert property ($rose(status_o.lost) |-> $past(status_o.mode) == MODE_ARB)
        else $error("lost flag set outside arbitration");
    fin_stop_a: assert property ($rose(status_o.fin) |-> !status_o.run && status_o.mode == MODE_MEAS)
        else $error("finish without stop");
    fin_clr_a: assert property (cw |=> !status_o.fin)
        else $error("finish flag not cleared");
endmodule

bind serial_line_arbiter serial_line_arbiter_checker chk_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .byteenable_i(byteenable_i), .writedata_i(writedata_i),
    .waitrequest_o(waitrequest_o), .tx_internal_i(tx_internal_i),
    .tx_pin_o(tx_pin_o), .status_o(status_o));

// ---- testbench/bus_node_model.sv ----
/*
 * Another node on the single-wire bus.
 * Assumes a pulled-up wire: a released line reads high.
 */
`timescale 1ns/1ps

module bus_node_model (
    input  wire logic dominant_i,
    input  wire logic tx_pin_i,
    output logic      rx_o
);
    // wired-and: any dominant node wins the wire
    assign rx_o = tx_pin_i & ~dominant_i;
endmodule

// ---- testbench/serial_line_arbiter_test.sv ----
/*
 * Self-checking bench for the serial line arbiter.
 * Assumes the design answers every register request after one wait cycle.
 */
`timescale 1ns/1ps

module serial_line_arbiter_test;
    import serial_line_arbiter_pkg::*;
    typedef struct packed {logic [3:0] a; logic w; logic [7:0] d; logic [7:0] e;} row_t;
    logic clk_i = 1'b0, rst_n_i = 1'b0, read_i = 1'b0, write_i = 1'b0;
    logic [3:0] address_i = 4'h0, byteenable_i = 4'h1;
    logic [31:0] writedata_i = 32'h0, readdata_o, r;
    logic waitrequest_o, presc_tick_i = 1'b0, tx_int = 1'b1, rx, tx_pin_o, dom = 1'b0;
    logic [1:0] tdiv = 2'h0;
    ctrl_view_t status_o;
    int fails = 0, n_tests = 0, cycles = 0;
    row_t rows[11] = '{'{4'h0, 1'b0, 8'h00, 8'h00}, '{4'h4, 1'b0, 8'h00, 8'h00},
        '{4'h0, 1'b1, 8'h40, 8'h00}, '{4'h0, 1'b0, 8'h00, 8'h40},
        '{4'h4, 1'b1, 8'hff, 8'h00}, '{4'h4, 1'b0, 8'h00, 8'h00},
        '{4'h8, 1'b0, 8'h00, 8'h00}, '{4'h0, 1'b1, 8'h30, 8'h00},
        '{4'h0, 1'b0, 8'h00, 8'h30}, '{4'h0, 1'b1, 8'h8f, 8'h00},
        '{4'h0, 1'b0, 8'h00, 8'h00}};
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        tdiv         <= tdiv + 2'h1;
        presc_tick_i <= (tdiv == 2'h3);
    end
    serial_line_arbiter dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .byteenable_i(byteenable_i),
        .writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
        .presc_tick_i(presc_tick_i), .tx_internal_i(tx_int), .rx_pin_i(rx),
        .tx_pin_o(tx_pin_o), .status_o(status_o));
    bus_node_model node_u (.dominant_i(dom), .tx_pin_i(tx_pin_o), .rx_o(rx));
    ////////////////////////////////////////////////////////////////////////
    task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d,
                       output logic [31:0] q);
        @(posedge clk_i);
        address_i   <= a;
        write_i     <= w;
        read_i      <= ~w;
        writedata_i <= {24'h0, d};
        @(posedge clk_i);
        while (waitrequest_o !== 1'b0) begin
            @(posedge clk_i);
        end
        q = readdata_o;
        write_i <= 1'b0;
        read_i  <= 1'b0;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic conclude;
        $display("fails=%0d n_tests=%0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ceiling well above the ~1700 cycles the sequence needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 10000) begin
            fails++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(19);
        chk(status_o, 32'h0);
        @(posedge clk_i) rst_n_i <= 1'b1;
        foreach (rows[i]) begin
            bus(rows[i].a, rows[i].w, rows[i].d, r);
            if (!rows[i].w) chk(r, {24'h0, rows[i].e});
        end
        // one fall, then let the count wrap
        bus(CTRL_OFS, 1'b1, 8'h10, r);
        @(posedge clk_i) dom <= 1'b1;
        cyc(4);
        @(posedge clk_i) dom <= 1'b0;
        cyc(1100);
        chk(status_o.ovf, 1'b1);
        chk(status_o.run, 1'b1);
        bus(CTRL_OFS, 1'b1, 8'h00, r);
        cyc(2);
        chk(status_o, 32'h0);
        bus(COUNT_OFS, 1'b0, 8'h00, r);
        chk(r, 32'h0);
        // falls 40 clocks apart give a count of 20
        bus(CTRL_OFS, 1'b1, 8'h10, r);
        @(posedge clk_i) dom <= 1'b1;
        cyc(4);
        @(posedge clk_i) dom <= 1'b0;
        cyc(20);
        chk(status_o.run, 1'b1);
        cyc(15);
        @(posedge clk_i) dom <= 1'b1;
        cyc(10);
        chk({status_o.fin, status_o.run}, 2'b10);
        bus(COUNT_OFS, 1'b0, 8'h00, r);
        chk(r >= 32'd19 && r <= 32'd21, 1'b1);
        // line already low when break timing is enabled
        bus(CTRL_OFS, 1'b1, 8'h50, r);
        cyc(6);
        chk(status_o.run, 1'b1);
        cyc(74);
        @(posedge clk_i) dom <= 1'b0;
        cyc(6);
        chk({status_o.fin, status_o.run}, 2'b10);
        bus(COUNT_OFS, 1'b0, 8'h00, r);
        chk(r >= 32'd9 && r <= 32'd12, 1'b1);
        // early transmit low must not rearm before the next rise
        bus(CTRL_OFS, 1'b1, 8'h20, r);
        @(posedge clk_i) tx_int <= 1'b0;
        cyc(2);
        @(posedge clk_i) tx_int <= 1'b1;
        cyc(40);
        @(posedge clk_i) tx_int <= 1'b0;
        cyc(4);
        chk(status_o.run, 1'b0);
        @(posedge clk_i) dom <= 1'b1;
        cyc(150);
        chk(status_o.lost, 1'b0);
        @(posedge clk_i) tx_int <= 1'b1;
        cyc(130);
        chk(status_o.lost, 1'b1);
        @(posedge clk_i) tx_int <= 1'b0;
        cyc(2);
        chk(tx_pin_o, 1'b1);
        bus(CTRL_OFS, 1'b1, 8'h20, r);
        cyc(2);
        chk(status_o.lost, 1'b1);
        bus(CTRL_OFS, 1'b1, 8'h00, r);
        cyc(2);
        chk(status_o.lost, 1'b0);
        // reset in the middle of a running measurement
        bus(CTRL_OFS, 1'b1, 8'h50, r);
        cyc(20);
        @(posedge clk_i) rst_n_i <= 1'b0;
        cyc(3);
        chk(status_o, 32'h0);
        @(posedge clk_i) rst_n_i <= 1'b1;
        conclude();
    end
endmodule
